// ### core/npps_consts.svh
// register map, field positions, command codes and timing counts
`ifndef NPPS_CONSTS_SVH
`define NPPS_CONSTS_SVH

// register byte offsets on the avalon slave
`define NPPS_OFS_CTRL 5'h00
`define NPPS_OFS_ROW 5'h04
`define NPPS_OFS_COL 5'h08
`define NPPS_OFS_LEN 5'h0C
`define NPPS_OFS_JUMP 5'h10
`define NPPS_OFS_DATA 5'h14
`define NPPS_OFS_STAT 5'h18

// control register fields
`define NPPS_CTRL_START 0
`define NPPS_CTRL_OP_LSB 1
`define NPPS_CTRL_OP_MSB 3
`define NPPS_CTRL_ENH 4
`define NPPS_CTRL_POLL 5
`define NPPS_CTRL_JUMP 6

// status register fields
`define NPPS_ST_BUSY 8
`define NPPS_ST_ORDER 9
`define NPPS_ST_REFUSED 10
`define NPPS_ST_FAIL 11
`define NPPS_ST_CPEND 12
`define NPPS_ST_RB 13
`define NPPS_ST_QUEUED 14

// bits of the die status byte
`define NPPS_DEV_FAIL 0
`define NPPS_DEV_CACHED_PRIOR_FAIL_FLAG 1
`define NPPS_DEV_ARRAY_READY_FLAG 5
`define NPPS_DEV_RDY 6

// command codes on the die bus
`define NPPS_CMD_SETUP 8'h80
`define NPPS_CMD_PROG 8'h10
`define NPPS_CMD_CACHE 8'h15
`define NPPS_CMD_QUEUE 8'h11
`define NPPS_CMD_JUMP 8'h85
`define NPPS_CMD_STAT 8'h70
`define NPPS_CMD_STATE 8'h78
`define NPPS_CMD_RESET 8'hFF

// reset values
`define NPPS_RST_WORD 32'h0000_0000
`define NPPS_RST_STAT 8'h00

// page field of the row address, highest page of a block
`define NPPS_PG_MSB 5
`define NPPS_LAST_PAGE 6'h3F

// strobe timing in ns and in cycles of the 250 mhz clock
`define NPPS_CLK_MHZ 250
`define NPPS_WE_LOW_NS 12
`define NPPS_WE_HIGH_NS 10
`define NPPS_RE_LOW_NS 32
`define NPPS_RE_HIGH_NS 12
`define NPPS_WB_NS 100
`define NPPS_CYC(ns) (((ns) * `NPPS_CLK_MHZ + 999) / 1000)
`define NPPS_WE_LOW_CYC `NPPS_CYC(`NPPS_WE_LOW_NS)
`define NPPS_WE_HIGH_CYC `NPPS_CYC(`NPPS_WE_HIGH_NS)
`define NPPS_RE_LOW_CYC `NPPS_CYC(`NPPS_RE_LOW_NS)
`define NPPS_RE_HIGH_CYC `NPPS_CYC(`NPPS_RE_HIGH_NS)
`define NPPS_WB_CYC `NPPS_CYC(`NPPS_WB_NS)

`endif

// ### core/npps_pkg.sv
// types shared by the page program sequencer
package npps_pkg;

	// sequencer states
	typedef enum logic [3:0] {
		S_IDLE = 4'h0,
		S_SETUP = 4'h1,
		S_ADDR = 4'h2,
		S_DATA = 4'h3,
		S_JCMD = 4'h4,
		S_JADDR = 4'h5,
		S_CONF = 4'h6,
		S_RSTC = 4'h7,
		S_WAITB = 4'h8,
		S_WAITRB = 4'h9,
		S_SCMD = 4'hA,
		S_SADDR = 4'hB,
		S_SREAD = 4'hC
	} npps_state_t;

	// operations software can order
	typedef enum logic [2:0] {
		OP_PROG = 3'h0,
		OP_CACHE = 3'h1,
		OP_QUEUE = 3'h2,
		OP_FINISH = 3'h3,
		OP_STATUS = 3'h4,
		OP_RESET = 3'h5
	} npps_op_t;

endpackage

// ### core/npps_buf_mem.sv
// page data buffer with registered read port
`timescale 1ns/1ps
module npps_buf_mem #(
	parameter int DEPTH = 4096,
	parameter int AW = 12
) (
	// clocking
	input wire logic core_clk,
	input wire logic ce,
	// write port
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [7:0] wdata,
	// read port
	input wire logic [AW-1:0] raddr,
	output logic [7:0] rdata_q
);

	logic [7:0] mem [DEPTH];

	// write and registered read, both frozen by clock enable
	always_ff @(posedge core_clk) begin
		if (ce) begin
			if (we) begin
				mem[waddr] <= wdata;
			end
			rdata_q <= mem[raddr];
		end
	end

endmodule

// ### core/npps_host_ctrl.sv
// host sequencer that programs pages of an asynchronous nand die
// How it works
// - program pages of a block in ascending order
// - after ready, check the pass/fail flag
// - fully busy: only status or reset allowed
// - cache ready only: program, status, reset allowed
// - queue commands 11h precede final program
// - address cycles, then serial data from column
// - 85h may change input column mid-data
// - track progress by ready pin or status
// - multi-die targets need enhanced status 78h
// - cache-ready only: check cached prior fail flag
// - finish caching: poll array ready, check flags
//
// Decided for this implementation: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "npps_consts.svh"
module npps_host_ctrl #(
	parameter int BUF_DEPTH = 4096,
	parameter int AW = 12
) (
	// clocking
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	// avalon slave
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// die pins
	output logic nand_ce_n,
	output logic nand_cle,
	output logic nand_ale,
	output logic nand_we_n,
	output logic nand_re_n,
	output logic nand_wp_n,
	output logic [7:0] nand_io_o,
	output logic nand_io_oe,
	input wire logic [7:0] nand_io_i,
	input wire logic nand_rb_n,
	// observation
	output npps_pkg::npps_state_t seq_state
);
	import npps_pkg::*;

	localparam logic [4:0] WLO = 5'(`NPPS_WE_LOW_CYC);
	localparam logic [4:0] WHI = 5'(`NPPS_WE_HIGH_CYC);
	localparam logic [4:0] RLO = 5'(`NPPS_RE_LOW_CYC);
	localparam logic [4:0] RHI = 5'(`NPPS_RE_HIGH_CYC);
	localparam logic [4:0] WEND = 5'd2 + WLO + WHI;
	localparam logic [4:0] RDONE = RLO + RHI;
	localparam logic [7:0] WBC = 8'(`NPPS_WB_CYC);

	typedef struct packed {
		npps_state_t st;
		logic [4:0] ph;
		logic [2:0] acnt;
		logic [7:0] wcnt;
		logic [15:0] idx;
		logic [7:0] sbyte;
		npps_op_t op;
		logic enh;
		logic poll;
		logic jmp;
		logic [23:0] row;
		logic [15:0] col;
		logic [15:0] len;
		logic [15:0] col2;
		logic [15:0] jat;
		logic [AW-1:0] wptr;
		logic ce_n;
		logic cle;
		logic ale;
		logic we_n;
		logic re_n;
		logic wp_n;
		logic [7:0] io_o;
		logic io_oe;
		logic [7:0] io_s1;
		logic [7:0] io_s2;
		logic [7:0] io_s3;
		logic [7:0] io_st;
		logic rb_s1;
		logic rb_s2;
		logic rb_s3;
		logic rb_st;
		logic busy;
		logic order_err;
		logic refused;
		logic fail;
		logic cache_pend;
		logic queued;
		logic [1:0][17:0] lblk;
		logic [1:0][6:0] npg;
		logic [1:0] lval;
		logic waitreq;
		logic [31:0] rdata;
	} npps_reg_t;

	npps_reg_t r_q;
	npps_reg_t r_d;
	logic [31:0] wmask;
	logic req;
	logic wr;
	logic start_req;
	logic [31:0] ctrl_wd;
	npps_op_t wd_op;
	logic [31:0] rd_mux;
	logic mem_we;
	logic [7:0] mem_rdata;
	logic pl;
	logic [17:0] blk;
	logic [6:0] exp_pg;
	logic order_ok;
	logic wr_st;
	logic wend;
	logic [9:0] wsel;
	logic goal;

	// merge written bytes into an old register value
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [31:0] m);
		merge = (old & ~m) | (nw & m);
	endfunction

	// confirm code of each program flavour
	function automatic logic [7:0] conf_code(input npps_op_t op);
		case (op)
			OP_CACHE: conf_code = `NPPS_CMD_CACHE;
			OP_QUEUE: conf_code = `NPPS_CMD_QUEUE;
			default: conf_code = `NPPS_CMD_PROG;
		endcase
	endfunction

	// address byte by cycle: column low, column high, row bytes
	function automatic logic [7:0] addr_byte(input logic [2:0] a,
		input logic [15:0] c, input logic [23:0] rw);
		case (a)
			3'h0: addr_byte = c[7:0];
			3'h1: addr_byte = c[15:8];
			3'h2: addr_byte = rw[7:0];
			3'h3: addr_byte = rw[15:8];
			default: addr_byte = rw[23:16];
		endcase
	endfunction

	// bus decode, one wait cycle then the answer
	assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	assign req = avs_read || avs_write;
	assign wr = avs_write && !r_q.waitreq;
	assign ctrl_wd = merge({25'h0, r_q.jmp, r_q.poll, r_q.enh, r_q.op, 1'b0},
		avs_writedata, wmask);
	assign wd_op = npps_op_t'(ctrl_wd[`NPPS_CTRL_OP_MSB:`NPPS_CTRL_OP_LSB]);
	assign start_req = wr && avs_address == `NPPS_OFS_CTRL
		&& ctrl_wd[`NPPS_CTRL_START];
	assign mem_we = wr && avs_address == `NPPS_OFS_DATA && avs_byteenable[0];

	// read data by offset, unmapped reads return zero
	assign rd_mux =
		(avs_address == `NPPS_OFS_CTRL) ?
			{25'h0, r_q.jmp, r_q.poll, r_q.enh, r_q.op, 1'b0} :
		(avs_address == `NPPS_OFS_ROW) ? {8'h00, r_q.row} :
		(avs_address == `NPPS_OFS_COL) ? {16'h0000, r_q.col} :
		(avs_address == `NPPS_OFS_LEN) ? {16'h0000, r_q.len} :
		(avs_address == `NPPS_OFS_JUMP) ? {r_q.jat, r_q.col2} :
		(avs_address == `NPPS_OFS_DATA) ? 32'(r_q.wptr) :
		(avs_address == `NPPS_OFS_STAT) ? {17'h00000, r_q.queued, r_q.rb_st,
			r_q.cache_pend, r_q.fail, r_q.refused, r_q.order_err, r_q.busy,
			r_q.sbyte} :
		32'h0000_0000;

	// next expected page per plane for the addressed block
	assign pl = r_q.row[`NPPS_PG_MSB + 1];
	assign blk = r_q.row[23:`NPPS_PG_MSB + 1];
	assign exp_pg = (r_q.lval[pl] && r_q.lblk[pl] == blk) ? r_q.npg[pl] : 7'h00;
	assign order_ok = {1'b0, r_q.row[`NPPS_PG_MSB:0]} == exp_pg;

	// strobed write cycles: cle, ale and the byte put on the bus
	assign wr_st = r_q.st inside {S_SETUP, S_ADDR, S_DATA, S_JCMD, S_JADDR,
		S_CONF, S_RSTC, S_SCMD, S_SADDR};
	assign wend = wr_st && r_q.ph == WEND;
	always_comb begin
		case (r_q.st)
			S_SETUP: wsel = {2'b10, `NPPS_CMD_SETUP};
			S_ADDR: wsel = {2'b01, addr_byte(r_q.acnt, r_q.col, r_q.row)};
			S_SADDR: wsel = {2'b01, addr_byte(r_q.acnt, r_q.col, r_q.row)};
			S_DATA: wsel = {2'b00, mem_rdata};
			S_JCMD: wsel = {2'b10, `NPPS_CMD_JUMP};
			S_JADDR: wsel = {2'b01, addr_byte(r_q.acnt, r_q.col2, r_q.row)};
			S_CONF: wsel = {2'b10, conf_code(r_q.op)};
			S_RSTC: wsel = {2'b10, `NPPS_CMD_RESET};
			S_SCMD: wsel = {2'b10, r_q.enh ? `NPPS_CMD_STATE : `NPPS_CMD_STAT};
			default: wsel = 10'h000;
		endcase
	end

	// array ready also needed when the whole program must be over
	assign goal = r_q.sbyte[`NPPS_DEV_RDY]
		&& (r_q.sbyte[`NPPS_DEV_ARRAY_READY_FLAG] || !(r_q.op inside {OP_PROG, OP_FINISH}));

	// next state of the whole controller
	always_comb begin
		r_d = r_q;
		// pin synchronisers, a change counts when stages two and three agree
		r_d.io_s1 = nand_io_i;
		r_d.io_s2 = r_q.io_s1;
		r_d.io_s3 = r_q.io_s2;
		if (r_q.io_s2 == r_q.io_s3) begin
			r_d.io_st = r_q.io_s3;
		end
		r_d.rb_s1 = nand_rb_n;
		r_d.rb_s2 = r_q.rb_s1;
		r_d.rb_s3 = r_q.rb_s2;
		if (r_q.rb_s2 == r_q.rb_s3) begin
			r_d.rb_st = r_q.rb_s3;
		end
		r_d.wp_n = 1'b1;
		// bus answer and register writes
		r_d.waitreq = !(req && r_q.waitreq);
		if (avs_read && r_q.waitreq) begin
			r_d.rdata = rd_mux;
		end
		if (wr) begin
			case (avs_address)
				`NPPS_OFS_CTRL: if (r_q.st == S_IDLE) begin
					r_d.op = wd_op;
					r_d.enh = ctrl_wd[`NPPS_CTRL_ENH];
					r_d.poll = ctrl_wd[`NPPS_CTRL_POLL];
					r_d.jmp = ctrl_wd[`NPPS_CTRL_JUMP];
				end else if (ctrl_wd[`NPPS_CTRL_START]) begin
					// a running sequence keeps its settings
					r_d.refused = 1'b1;
				end
				`NPPS_OFS_ROW: r_d.row = 24'(merge({8'h00, r_q.row},
					avs_writedata, wmask));
				`NPPS_OFS_COL: r_d.col = 16'(merge({16'h0000, r_q.col},
					avs_writedata, wmask));
				`NPPS_OFS_LEN: r_d.len = 16'(merge({16'h0000, r_q.len},
					avs_writedata, wmask));
				`NPPS_OFS_JUMP: begin
					{r_d.jat, r_d.col2} = merge({r_q.jat, r_q.col2},
						avs_writedata, wmask);
				end
				`NPPS_OFS_DATA: if (mem_we) r_d.wptr = r_q.wptr + 1'b1;
				`NPPS_OFS_STAT: begin
					// error flags clear on writing one; later sets win
					if (avs_writedata[`NPPS_ST_ORDER] && avs_byteenable[1])
						r_d.order_err = 1'b0;
					if (avs_writedata[`NPPS_ST_REFUSED] && avs_byteenable[1])
						r_d.refused = 1'b0;
					if (avs_writedata[`NPPS_ST_FAIL] && avs_byteenable[1])
						r_d.fail = 1'b0;
				end
				default: ;
			endcase
		end
		// generic write strobe: load, we low, we high
		if (wr_st) begin
			r_d.ph = r_q.ph + 5'd1;
			if (r_q.ph == 5'd1) begin
				{r_d.cle, r_d.ale, r_d.io_o} = wsel;
				r_d.io_oe = 1'b1;
			end
			if (r_q.ph == 5'd2) r_d.we_n = 1'b0;
			if (r_q.ph == WLO + 5'd2) r_d.we_n = 1'b1;
			if (wend) begin
				r_d.ph = 5'd0;
				r_d.cle = 1'b0;
				r_d.ale = 1'b0;
			end
		end
		// sequencer
		case (r_q.st)
			S_IDLE: begin
				r_d.ce_n = 1'b1;
				r_d.io_oe = 1'b0;
				r_d.ph = 5'd0;
				if (start_req) begin
					case (wd_op)
						OP_PROG, OP_CACHE, OP_QUEUE: begin
							if (!order_ok) begin
								r_d.order_err = 1'b1;
							end else if (wd_op == OP_QUEUE && r_q.cache_pend) begin
								r_d.refused = 1'b1;
							end else begin
								// 10h and 15h allowed while caching
								r_d.st = S_SETUP;
								r_d.busy = 1'b1;
								r_d.ce_n = 1'b0;
								r_d.idx = 16'h0000;
								r_d.lval[pl] = 1'b1;
								r_d.lblk[pl] = blk;
								r_d.npg[pl] = {1'b0, r_q.row[`NPPS_PG_MSB:0]} + 7'h01;
							end
						end
						OP_FINISH, OP_STATUS: begin
							r_d.st = S_SCMD;
							r_d.busy = 1'b1;
							r_d.ce_n = 1'b0;
						end
						OP_RESET: begin
							r_d.st = S_RSTC;
							r_d.busy = 1'b1;
							r_d.ce_n = 1'b0;
						end
						default: r_d.refused = 1'b1;
					endcase
				end
			end
			S_SETUP: if (wend) begin
				r_d.st = S_ADDR;
				r_d.acnt = 3'h0;
			end
			S_ADDR: if (wend) begin
				r_d.acnt = r_q.acnt + 3'h1;
				if (r_q.acnt == 3'h4) begin
					r_d.st = (r_q.len == 16'h0000) ? S_CONF : S_DATA;
				end
			end
			S_DATA: if (wend) begin
				r_d.idx = r_q.idx + 16'h0001;
				if (r_q.idx + 16'h0001 == r_q.len) begin
					r_d.st = S_CONF;
				end else if (r_q.jmp && r_q.idx + 16'h0001 == r_q.jat) begin
					r_d.st = S_JCMD;
				end
			end
			S_JCMD: if (wend) begin
				r_d.st = S_JADDR;
				r_d.acnt = 3'h0;
			end
			S_JADDR: if (wend) begin
				r_d.acnt = r_q.acnt + 3'h1;
				if (r_q.acnt == 3'h1) r_d.st = S_DATA;
			end
			S_CONF: if (wend) begin
				// queue 11h keeps caches; 10h or 15h ends the group
				r_d.st = S_WAITB;
				r_d.wcnt = 8'h00;
				r_d.wptr = '0;
				r_d.queued = (r_q.op == OP_QUEUE);
			end
			S_RSTC: if (wend) begin
				r_d.st = S_WAITB;
				r_d.wcnt = 8'h00;
				r_d.queued = 1'b0;
			end
			S_WAITB: begin
				// no command and bus released for WBC cycles after the confirm or reset
				r_d.io_oe = 1'b0;
				r_d.wcnt = r_q.wcnt + 8'h01;
				if (r_q.wcnt == WBC - 8'h01) begin
					r_d.st = r_q.poll ? S_SCMD : S_WAITRB;
				end
			end
			S_WAITRB: if (r_q.rb_st) r_d.st = S_SCMD;
			S_SCMD: if (wend) begin
				r_d.st = r_q.enh ? S_SADDR : S_SREAD;
				r_d.acnt = 3'h2;
			end
			S_SADDR: if (wend) begin
				r_d.acnt = r_q.acnt + 3'h1;
				if (r_q.acnt == 3'h4) r_d.st = S_SREAD;
			end
			S_SREAD: begin
				r_d.ph = r_q.ph + 5'd1;
				if (r_q.ph == 5'd0) begin
					r_d.re_n = 1'b0;
					r_d.io_oe = 1'b0;
				end
				if (r_q.ph == RLO) begin
					r_d.sbyte = r_q.io_st;
					r_d.re_n = 1'b1;
				end
				if (r_q.ph == RDONE) begin
					r_d.ph = 5'd0;
					if (r_q.op != OP_STATUS && !goal) begin
						r_d.st = S_SCMD;
					end else begin
						r_d.st = S_IDLE;
						r_d.busy = 1'b0;
						r_d.ce_n = 1'b1;
						r_d.cache_pend = !r_q.sbyte[`NPPS_DEV_ARRAY_READY_FLAG];
						if (r_q.op inside {OP_PROG, OP_FINISH}
							&& r_q.sbyte[`NPPS_DEV_FAIL]) begin
							r_d.fail = 1'b1;
						end
						if (r_q.op inside {OP_CACHE, OP_FINISH}
							&& r_q.sbyte[`NPPS_DEV_CACHED_PRIOR_FAIL_FLAG]) begin
							r_d.fail = 1'b1;
						end
					end
				end
			end
			default: r_d.st = S_IDLE;
		endcase
	end

	// state register with synchronous reset and clock enable
	always_ff @(posedge core_clk) begin
		if (rst) begin
			r_q <= '0;
			r_q.st <= S_IDLE;
			r_q.op <= OP_PROG;
			r_q.sbyte <= `NPPS_RST_STAT;
			r_q.ce_n <= 1'b1;
			r_q.we_n <= 1'b1;
			r_q.re_n <= 1'b1;
			r_q.waitreq <= 1'b1;
			r_q.rdata <= `NPPS_RST_WORD;
		end else if (ce) begin
			r_q <= r_d;
		end
	end

	npps_buf_mem #(.DEPTH(BUF_DEPTH), .AW(AW)) u_buf (
		.core_clk(core_clk),
		.ce(ce),
		.we(mem_we),
		.waddr(r_q.wptr),
		.wdata(avs_writedata[7:0]),
		.raddr(r_q.idx[AW-1:0]),
		.rdata_q(mem_rdata)
	);

	// outputs straight from the state register
	assign avs_readdata = r_q.rdata;
	assign avs_waitrequest = r_q.waitreq;
	assign nand_ce_n = r_q.ce_n;
	assign nand_cle = r_q.cle;
	assign nand_ale = r_q.ale;
	assign nand_we_n = r_q.we_n;
	assign nand_re_n = r_q.re_n;
	assign nand_wp_n = r_q.wp_n;
	assign nand_io_o = r_q.io_o;
	assign nand_io_oe = r_q.io_oe;
	assign seq_state = r_q.st;

	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst || !ce);

	sequence s_read_end;
		r_q.st == S_SREAD && r_q.ph == RDONE;
	endsequence

	chk_strobes_excl: assert property (nand_we_n || nand_re_n)
		else $error("write and read strobes low together");
	chk_setup_code: assert property ((r_q.st == S_SETUP && r_q.ph == 5'd3)
		|-> (nand_io_o == 8'h80 && nand_cle && !nand_ale))
		else $error("setup cycle does not carry 80h");
	chk_order_refuse: assert property ((start_req && r_q.st == S_IDLE
		&& wd_op inside {OP_PROG, OP_CACHE, OP_QUEUE} && !order_ok)
		|=> (r_q.order_err && r_q.st == S_IDLE))
		else $error("out of order page not refused");
	chk_prog_confirm: assert property ((r_q.st == S_CONF
		&& r_q.op == OP_PROG && r_q.ph == 5'd3) |-> nand_io_o == 8'h10)
		else $error("page program confirm is not 10h");
	chk_cache_confirm: assert property ((r_q.st == S_CONF
		&& r_q.op == OP_CACHE && r_q.ph == 5'd3) |-> nand_io_o == 8'h15)
		else $error("cache program confirm is not 15h");
	chk_queue_confirm: assert property ((r_q.st == S_CONF
		&& r_q.op == OP_QUEUE && r_q.ph == 5'd3) |-> nand_io_o == 8'h11)
		else $error("queue confirm is not 11h");
	chk_busy_quiet: assert property ((r_q.st == S_WAITRB)
		|-> (nand_we_n && nand_re_n && !nand_io_oe))
		else $error("bus driven while die is busy");
	chk_queue_refuse: assert property ((start_req && r_q.st == S_IDLE
		&& wd_op == OP_QUEUE && order_ok && r_q.cache_pend)
		|=> (r_q.refused && r_q.st == S_IDLE))
		else $error("queue command issued while caching");
	chk_status_code: assert property ((r_q.st == S_SCMD
		&& r_q.ph == 5'd3) |-> nand_io_o == (r_q.enh ? 8'h78 : 8'h70))
		else $error("wrong status command code");
	chk_jump_code: assert property ((r_q.st == S_JCMD
		&& r_q.ph == 5'd3) |-> (nand_io_o == 8'h85 && nand_cle))
		else $error("column change command is not 85h");
	chk_rb_status: assert property ((r_q.st == S_WAITRB && r_q.rb_st)
		|=> r_q.st == S_SCMD ##[1:12] (r_q.st == S_SCMD && !nand_we_n))
		else $error("ready pin does not lead to status read");
	chk_finish_poll: assert property ((s_read_end ##0
		(r_q.op == OP_FINISH && !r_q.sbyte[5])) |=> r_q.st == S_SCMD)
		else $error("finish stopped before array ready");
	chk_fail_catch: assert property ((s_read_end ##0 (r_q.op == OP_PROG
		&& r_q.sbyte[0] && r_q.sbyte[6] && r_q.sbyte[5])) |=> r_q.fail)
		else $error("program failure not reported");
	chk_we_width: assert property ($fell(nand_we_n)
		|-> !nand_we_n [*3] ##1 nand_we_n)
		else $error("write strobe low time wrong");
	chk_bus_answer: assert property ((req && avs_waitrequest)
		|=> !avs_waitrequest)
		else $error("bus request not answered in one cycle");

endmodule

// ### tb/npps_die_model.sv
// behavioural die that logs bus writes and answers status reads
`timescale 1ns/1ps
`include "npps_consts.svh"
module npps_die_model #(
	parameter int PROG_T = 200,
	parameter int CBSY_T = 40,
	parameter int DBSY_T = 20
) (
	// clock and host pins
	input wire logic clk,
	input wire logic ce_n,
	input wire logic cle,
	input wire logic ale,
	input wire logic we_n,
	input wire logic re_n,
	input wire logic [7:0] io,
	input wire logic fail_i,
	// die answers
	output logic [7:0] io_i,
	output logic rb_n
);
	int log_q[$];
	int busy = 0;
	int arr = 0;
	int bad = 0;
	int nbytes = 0;
	logic queued = 1'b0;
	logic we_q = 1'b1;
	logic [7:0] sts;
	// status byte from the two busy counters and the fail input
	always_comb begin
		sts = 8'h00;
		sts[`NPPS_DEV_RDY] = (busy == 0);
		sts[`NPPS_DEV_ARRAY_READY_FLAG] = (arr == 0);
		sts[`NPPS_DEV_FAIL] = fail_i;
	end
	// a released bus shows the inverse, never the last value
	assign io_i = (!ce_n && !re_n) ? sts : ~sts;
	assign rb_n = (busy == 0);
	// byte capture on write strobe rise, busy countdown
	always @(posedge clk) begin
		we_q <= we_n;
		if (busy > 0)
			busy <= busy - 1;
		if (arr > 0)
			arr <= arr - 1;
		if (!we_q && we_n && !ce_n) begin
			log_q.push_back({cle, ale, io});
			if (!cle)
				nbytes <= nbytes + !ale;
			else begin
				if (busy > 0 && !(io inside {8'h70, 8'h78, 8'hFF}))
					bad <= bad + 1;
				if (busy == 0 && arr > 0 && !(io inside {8'h70, 8'h78,
					8'h80, 8'h10, 8'h15, 8'h85, 8'hFF}))
					bad <= bad + 1;
				case (io)
				`NPPS_CMD_SETUP: if (!queued) nbytes <= 0;
				`NPPS_CMD_PROG: begin
					busy <= PROG_T + arr;
					arr <= PROG_T + arr;
					queued <= 1'b0;
				end
				`NPPS_CMD_CACHE: begin
					busy <= CBSY_T + arr;
					arr <= CBSY_T + arr + PROG_T;
					queued <= 1'b0;
				end
				`NPPS_CMD_QUEUE: begin
					busy <= DBSY_T;
					queued <= 1'b1;
				end
				`NPPS_CMD_RESET: begin
					busy <= 0;
					arr <= 0;
					queued <= 1'b0;
				end
				default: ;
				endcase
			end
		end
	end
endmodule

// ### tb/npps_host_ctrl_test.sv
// self-checking bench for the page program sequencer
`timescale 1ns/1ps
`include "npps_consts.svh"
module npps_host_ctrl_test;
	import npps_pkg::*;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic fail_i = 1'b0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [4:0] avs_address = 5'h00;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata, q;
	logic avs_waitrequest, nand_ce_n, nand_cle, nand_ale, nand_we_n;
	logic nand_re_n, nand_wp_n, nand_io_oe, nand_rb_n;
	logic [7:0] nand_io_o, nand_io_i;
	logic [7:0] lfsr = 8'h14;
	npps_state_t seq_state;
	int failures = 0;
	int n_tests = 0;
	int exp_q[$];
	// design and die
	npps_host_ctrl dut_u (.core_clk(core_clk), .rst(rst), .ce(1'b1),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hF), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .nand_ce_n(nand_ce_n),
		.nand_cle(nand_cle), .nand_ale(nand_ale), .nand_we_n(nand_we_n),
		.nand_re_n(nand_re_n), .nand_wp_n(nand_wp_n),
		.nand_io_o(nand_io_o), .nand_io_oe(nand_io_oe),
		.nand_io_i(nand_io_i), .nand_rb_n(nand_rb_n),
		.seq_state(seq_state));
	npps_die_model die_u (.clk(core_clk), .ce_n(nand_ce_n), .cle(nand_cle),
		.ale(nand_ale), .we_n(nand_we_n), .re_n(nand_re_n), .io(nand_io_o),
		.fail_i(fail_i), .io_i(nand_io_i), .rb_n(nand_rb_n));
	// clock
	initial forever #2 core_clk = ~core_clk;
	// compare and count
	task chk(input logic [31:0] got, input logic [31:0] want);
		n_tests++;
		if (got !== want) begin
			failures++;
			$display("MISMATCH %0t got %h want %h", $time, got, want);
		end
	endtask
	// next value of the stimulus shift register
	function automatic logic [7:0] lfsr_next(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	// one avalon transfer held until waitrequest is seen low
	task av(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge core_clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	// poll status until the sequencer is idle
	task wait_idle;
		for (int k = 0; k < 500; k++) begin
			av(1'b0, `NPPS_OFS_STAT, 32'h0);
			if (q[`NPPS_ST_BUSY] === 1'b0)
				return;
		end
		failures++;
		$display("MISMATCH %0t sequencer stuck busy", $time);
		end_of_test();
	endtask
	// load, start, wait, then compare the die log with the expectation
	task run(input int op, input logic [23:0] row, input int len,
		input logic [31:0] fl);
		int base;
		base = die_u.log_q.size();
		exp_q.delete();
		av(1'b1, `NPPS_OFS_ROW, {8'h00, row});
		av(1'b1, `NPPS_OFS_COL, 32'h0);
		av(1'b1, `NPPS_OFS_LEN, len);
		if (fl[6])
			av(1'b1, `NPPS_OFS_JUMP, 32'h0001_01A3);
		if (op < 3)
			exp_q = {10'h280, 10'h100, 10'h100, 10'h100 + row[7:0],
				10'h100 + row[15:8], 10'h100 + row[23:16]};
		for (int k = 0; k < len; k++) begin
			av(1'b1, `NPPS_OFS_DATA, {24'h0, lfsr});
			exp_q.push_back(lfsr);
			lfsr = lfsr_next(lfsr);
			if (fl[6] && k == 0 && len > 1)
				exp_q = {exp_q, 10'h285, 10'h1A3, 10'h101};
		end
		if (op < 3)
			exp_q.push_back(10'h200 + (op == 0 ? `NPPS_CMD_PROG :
				op == 1 ? `NPPS_CMD_CACHE : `NPPS_CMD_QUEUE));
		else if (op == 5)
			exp_q.push_back(10'h2FF);
		else if (op == 4)
			exp_q = {10'h278, 10'h100 + row[7:0], 10'h100 + row[15:8],
				10'h100 + row[23:16]};
		else
			exp_q.push_back(10'h270);
		av(1'b1, `NPPS_OFS_CTRL, fl | (op << 1) | 1);
		wait_idle();
		for (int k = 0; k < exp_q.size(); k++)
			chk(die_u.log_q[base + k], exp_q[k]);
	endtask
	// verdict
	task end_of_test;
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// watchdog
	initial begin
		repeat (60000) @(posedge core_clk);
		failures++;
		$display("MISMATCH %0t watchdog expired", $time);
		end_of_test();
	end
	// main sequence
	initial begin
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		av(1'b0, `NPPS_OFS_STAT, 32'h0);
		chk(q[12:8], 5'h00);
		chk({nand_wp_n, nand_ce_n, nand_we_n, nand_re_n, nand_io_oe,
			seq_state}, {5'b11110, S_IDLE});
		av(1'b0, `NPPS_OFS_CTRL, 32'h0);
		chk(q, 32'h0);
		av(1'b0, 5'h1C, 32'h0);
		chk(q, 32'h0);
		run(0, 24'h000000, 3, 0);
		chk(q[`NPPS_DEV_RDY], 1'b1);
		chk(q[`NPPS_ST_FAIL], 1'b0);
		chk(die_u.nbytes, 3);
		run(2, 24'h000040, 2, 0);
		chk(q[`NPPS_ST_QUEUED], 1'b1);
		run(0, 24'h000001, 2, 0);
		chk(die_u.nbytes, 4);
		run(1, 24'h000002, 2, 0);
		chk(q[`NPPS_ST_CPEND], 1'b1);
		// queue order while caching is refused
		av(1'b1, `NPPS_OFS_ROW, 32'h41);
		av(1'b1, `NPPS_OFS_CTRL, 32'h5);
		av(1'b0, `NPPS_OFS_STAT, 32'h0);
		chk(q[`NPPS_ST_REFUSED], 1'b1);
		av(1'b1, `NPPS_OFS_STAT, 32'h400);
		run(1, 24'h000003, 2, 32'h20);
		run(3, 24'h000003, 0, 0);
		chk(q[`NPPS_ST_CPEND], 1'b0);
		run(2, 24'h000041, 2, 0);
		run(1, 24'h000004, 2, 32'h40);
		run(0, 24'h000005, 1, 0);
		chk(q[`NPPS_ST_CPEND], 1'b0);
		// skipped page
		av(1'b1, `NPPS_OFS_ROW, 32'h7);
		av(1'b1, `NPPS_OFS_LEN, 32'h0);
		av(1'b1, `NPPS_OFS_CTRL, 32'h1);
		wait_idle();
		chk(q[`NPPS_ST_ORDER], 1'b1);
		av(1'b1, `NPPS_OFS_STAT, 32'h200);
		av(1'b0, `NPPS_OFS_STAT, 32'h0);
		chk(q[`NPPS_ST_ORDER], 1'b0);
		fail_i <= 1'b1;
		run(0, 24'h000080, 1, 0);
		chk(q[`NPPS_ST_FAIL], 1'b1);
		fail_i <= 1'b0;
		run(4, 24'h000080, 0, 32'h10);
		run(5, 24'h000080, 0, 0);
		chk(die_u.bad, 0);
		end_of_test();
	end
endmodule
